// ==== rtl/hcm_defs.svh ====
// Constants for the host command doorbell mailbox: offsets, fields, codes.
// Overview of operation
// R1: Commands carry bit 15; doorbell interrupts processor.
// R2: Host loads parameters before writing command.
// R3: Doorbell captures command copy, hands to processor.
// R4: Completion clears doorbell, leaves result code.
// R5: Response parameters return through the pool.
// R6: Host waits for completion before new traffic.
// R7: Host checks doorbell clear before issuing.
// R8: Synchronous command reports operation outcome.
// R9: Accepted asynchronous command returns success, runs on.
// R10: Host reads non-success async reply as refused.
// R11: Status query answers busy while operation runs.
// R12: Host repeats status query until not busy.
// R13: Start-up lock rejects every command as busy.
// R14: Lock frees when start-up configuration finishes.
// R15: Host polls doorbell, then get-state until ready.
// R16: Running internal command rejects host as busy.
// R17: Unknown command rejected as unsupported.
// R18: Result codes follow the fixed status table.
// R19: Host writes 16-bit address, then 16-bit data.
// R20: Host bounds every polling loop with retries.
// R21: Doorbell stays set until result is written.
`ifndef HCM_DEFS_SVH
`define HCM_DEFS_SVH

// Register map on the 16-bit serial register space.
`define HCM_CMD_ADDR 16'h0040
`define HCM_POOL_BASE_HI 11'h7e0
`define HCM_POOL_DEPTH 16
`define HCM_POOL_AW 4

// Field positions and reset values.
`define HCM_DOORBELL_BIT 15
`define HCM_CMD_RESET 16'h0000
`define HCM_LOCK_RESET 1'b1
`define HCM_RESULT_PAD 8'h00

// Result status codes (see R18).
`define HCM_STATUS_OK 8'h00
`define HCM_STATUS_NO_ENTITY 8'h01
`define HCM_STATUS_INTERRUPTED 8'h02
`define HCM_STATUS_IO_FAILURE 8'h03
`define HCM_STATUS_TOO_LARGE 8'h04
`define HCM_STATUS_BAD_HANDLE 8'h05
`define HCM_STATUS_RETRY_LATER 8'h06
`define HCM_STATUS_NO_MEMORY 8'h07
`define HCM_STATUS_DENIED 8'h08
`define HCM_STATUS_BUSY 8'h09
`define HCM_STATUS_EXISTS 8'h0a
`define HCM_STATUS_NO_DEVICE 8'h0b
`define HCM_STATUS_INVALID_ARG 8'h0c
`define HCM_STATUS_NO_SPACE 8'h0d
`define HCM_STATUS_OUT_OF_RANGE 8'h0e
`define HCM_STATUS_UNSUPPORTED 8'h0f
`define HCM_STATUS_ALREADY_REQUESTED 8'h10

`endif

// ==== rtl/hcm_pkg.sv ====
// Types shared by the host command mailbox modules.
package hcm_pkg;
  // Command sequencing states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_WAIT = 2'b10
  } hcm_state_e;
  // One register word of the serial register space.
  typedef logic [15:0] hcm_word_t;
  // One result status code.
  typedef logic [7:0] hcm_status_t;
endpackage

// ==== rtl/hcm_cmd_classify.sv ====
// Command word classifier: known, asynchronous and status-query commands.
`timescale 1ns/100ps
`default_nettype none
module hcm_cmd_classify (
  input wire logic [15:0] cmd,
  output logic known,
  output logic is_async,
  output logic is_query
);
  // Pure table lookup; codes outside the catalogue are reported unknown.
  always_comb begin
    known = 1'b1;
    is_async = 1'b0;
    is_query = 1'b0;
    case (cmd) inside
      16'h8100, 16'h8206, 16'h820e, 16'h8311, 16'h8500, [16'h8504:16'h8508],
      16'h8606, 16'h8700, 16'h8702, 16'h8b00: begin
        is_async = 1'b1;
      end
      16'h8207, 16'h8312, 16'h8501, 16'h8509, 16'h8607, 16'h8701: begin
        is_query = 1'b1;
      end
      [16'h8101:16'h8102], [16'h8200:16'h820d], 16'h8310, 16'h8313,
      [16'h8400:16'h8405], 16'h8502, 16'h8503, 16'h850a, 16'h8706,
      [16'h8900:16'h8902], 16'h8b01: begin
        known = 1'b1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/hcm_param_pool.sv ====
// Shared parameter pool written by the host and by the processor.
`timescale 1ns/100ps
`include "hcm_defs.svh"
`default_nettype none
module hcm_param_pool (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_we,
  input wire logic [3:0] host_idx,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  input wire logic proc_we,
  input wire logic [3:0] proc_idx,
  input wire logic [15:0] proc_wdata,
  output logic [15:0] proc_rdata
);
  // Pool storage, one word per parameter slot.
  logic [15:0] mem_q [`HCM_POOL_DEPTH];
  logic [15:0] mem_d [`HCM_POOL_DEPTH];

  // Next contents; a processor write beats a host write to the same slot.
  always_comb begin
    mem_d = mem_q;
    if (host_we) begin
      mem_d[host_idx] = host_wdata;
    end
    if (proc_we) begin
      mem_d[proc_idx] = proc_wdata; // see R5
    end
  end

  // Registers only; cleared so that a read before any write is defined.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `HCM_POOL_DEPTH; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  // Both read ports are combinational; callers register them.
  assign host_rdata = mem_q[host_idx];
  assign proc_rdata = mem_q[proc_idx];
endmodule
`default_nettype wire

// ==== rtl/hcm_mailbox.sv ====
// Host command doorbell mailbox: command register, lock and dispatch.
`timescale 1ns/100ps
`include "hcm_defs.svh"
`default_nettype none
module hcm_mailbox (
  input wire logic clk,
  input wire logic rst_b,
  // Decoded register port from the serial slave, same clock.
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rd_valid,
  // Internal status from the rest of the device.
  input wire logic cfg_done,
  input wire logic internal_cmd_active,
  // Processor side of the doorbell.
  output logic proc_irq,
  output logic [15:0] proc_cmd_word,
  output logic proc_cmd_async,
  input wire logic proc_done,
  input wire logic [7:0] proc_result,
  input wire logic proc_async_done,
  // Processor access to the parameter pool.
  input wire logic proc_pool_we,
  input wire logic [3:0] proc_pool_idx,
  input wire logic [15:0] proc_pool_wdata,
  output logic [15:0] proc_pool_rdata,
  // Visible state for the rest of the device.
  output logic cmd_locked,
  output logic async_running
);

  // True when a register address falls in the pool window.
  function automatic logic in_pool(input logic [15:0] a);
    in_pool = (a[15:5] == `HCM_POOL_BASE_HI) && !a[0];
  endfunction

  // Pool slot addressed by a register address.
  function automatic logic [3:0] pool_idx(input logic [15:0] a);
    pool_idx = a[4:1];
  endfunction

  // Result word: status in the low byte, doorbell bit clear.
  function automatic hcm_pkg::hcm_word_t result_word(
    input hcm_pkg::hcm_status_t s
  );
    result_word = {`HCM_RESULT_PAD, s};
  endfunction

  // Command state.
  hcm_pkg::hcm_state_e state_q;
  hcm_pkg::hcm_state_e state_d;
  // Command register as the host sees it.
  hcm_pkg::hcm_word_t cmd_q;
  hcm_pkg::hcm_word_t cmd_d;
  // Doorbell interrupt towards the processor.
  logic irq_q;
  logic irq_d;
  // Captured copy of the command for the processor.
  hcm_pkg::hcm_word_t word_q;
  hcm_pkg::hcm_word_t word_d;
  // Whether the dispatched command is asynchronous.
  logic async_q;
  logic async_d;
  // Start-up command lock.
  logic lock_q;
  logic lock_d;
  // An accepted asynchronous operation is still running.
  logic run_q;
  logic run_d;
  // Register read path.
  hcm_pkg::hcm_word_t rdata_q;
  hcm_pkg::hcm_word_t rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  // Registered processor pool read.
  hcm_pkg::hcm_word_t prd_q;
  hcm_pkg::hcm_word_t prd_d;

  // Decoded command class and pool wiring.
  logic cmd_known;
  logic cmd_is_async;
  logic cmd_is_query;
  logic host_cmd_wr;
  logic host_pool_we;
  logic [15:0] host_pool_rdata;
  logic [15:0] proc_pool_rd;
  logic reject;

  // A host write that targets the command register.
  assign host_cmd_wr = reg_wr_en && (reg_addr == `HCM_CMD_ADDR);
  // The pool accepts host writes at any time; ordering is the host's job.
  assign host_pool_we = reg_wr_en && in_pool(reg_addr); // see R2

  // Classifier looks at the held command register.
  hcm_cmd_classify u_classify (
    .cmd(cmd_q),
    .known(cmd_known),
    .is_async(cmd_is_async),
    .is_query(cmd_is_query)
  );

  // Parameter pool shared with the processor.
  hcm_param_pool u_pool (
    .clk(clk),
    .rst_b(rst_b),
    .host_we(host_pool_we),
    .host_idx(pool_idx(reg_addr)),
    .host_wdata(reg_wdata),
    .host_rdata(host_pool_rdata),
    .proc_we(proc_pool_we),
    .proc_idx(proc_pool_idx),
    .proc_wdata(proc_pool_wdata),
    .proc_rdata(proc_pool_rd)
  );

  // Any reason to answer a command without waking the processor.
  assign reject = lock_q || internal_cmd_active || !cmd_known ||
                  (cmd_is_query && run_q);

  // Next-state logic for the command register and dispatch.
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    irq_d = irq_q;
    word_d = word_q;
    async_d = async_q;
    // The lock only ever opens; nothing re-arms it short of reset.
    lock_d = lock_q && !cfg_done; // see R14
    run_d = run_q;
    // The background task reports that the operation has ended.
    if (proc_async_done) begin
      run_d = 1'b0;
    end
    case (state_q)
      hcm_pkg::ST_IDLE: begin
        // Only a word with the doorbell bit set starts a command.
        if (host_cmd_wr && reg_wdata[`HCM_DOORBELL_BIT]) begin
          cmd_d = reg_wdata; // see R1
          state_d = hcm_pkg::ST_CHECK;
        end
      end
      hcm_pkg::ST_CHECK: begin
        // Host writes here are dropped so the doorbell cannot clear early.
        if (lock_q) begin
          cmd_d = result_word(`HCM_STATUS_BUSY); // see R13
          state_d = hcm_pkg::ST_IDLE;
        end else if (internal_cmd_active) begin
          cmd_d = result_word(`HCM_STATUS_BUSY); // see R16
          state_d = hcm_pkg::ST_IDLE;
        end else if (!cmd_known) begin
          cmd_d = result_word(`HCM_STATUS_UNSUPPORTED); // see R17
          state_d = hcm_pkg::ST_IDLE;
        end else if (cmd_is_query && run_q) begin
          cmd_d = result_word(`HCM_STATUS_BUSY); // see R11
          state_d = hcm_pkg::ST_IDLE;
        end else begin
          // Copy taken in the same edge as the interrupt rises.
          irq_d = 1'b1; // see R3
          word_d = cmd_q;
          async_d = cmd_is_async;
          state_d = hcm_pkg::ST_WAIT;
        end
      end
      hcm_pkg::ST_WAIT: begin
        // The processor's answer is the outcome for synchronous commands.
        if (proc_done) begin
          irq_d = 1'b0;
          cmd_d = result_word(proc_result); // see R4, R8
          state_d = hcm_pkg::ST_IDLE;
          // A start that coincides with an old end leaves the flag set.
          if (async_q && (proc_result == `HCM_STATUS_OK)) begin
            run_d = 1'b1; // see R9
          end
        end
      end
      default: begin
        state_d = hcm_pkg::ST_IDLE;
      end
    endcase
  end

  // Registers for the command group.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= hcm_pkg::ST_IDLE;
      cmd_q <= `HCM_CMD_RESET;
      irq_q <= 1'b0;
      word_q <= `HCM_CMD_RESET;
      async_q <= 1'b0;
      lock_q <= `HCM_LOCK_RESET;
      run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      irq_q <= irq_d;
      word_q <= word_d;
      async_q <= async_d;
      lock_q <= lock_d;
      run_q <= run_d;
    end
  end

  // Read mux; unmapped addresses answer zero.
  always_comb begin
    rdata_d = 16'h0000;
    rvalid_d = reg_rd_en;
    if (reg_rd_en) begin
      if (reg_addr == `HCM_CMD_ADDR) begin
        rdata_d = cmd_q; // see R21
      end else if (in_pool(reg_addr)) begin
        rdata_d = host_pool_rdata; // see R5
      end else begin
        rdata_d = 16'h0000;
      end
    end
    prd_d = proc_pool_rd;
  end

  // Registers for the read group.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      prd_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      prd_q <= prd_d;
    end
  end

  // Every output is a flip-flop.
  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rvalid_q;
  assign proc_irq = irq_q;
  assign proc_cmd_word = word_q;
  assign proc_cmd_async = async_q;
  assign proc_pool_rdata = prd_q;
  assign cmd_locked = lock_q;
  assign async_running = run_q;

  // Checks share one clock and the reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A doorbell write in idle shows set and moves to checking.
  property p_doorbell_set;
    (state_q == hcm_pkg::ST_IDLE) && host_cmd_wr && reg_wdata[15]
      |=> cmd_q[15] && (state_q == hcm_pkg::ST_CHECK);
  endproperty
  a_doorbell_set: assert property (p_doorbell_set) // see R1
    else $error("doorbell write not taken");

  // An accepted command raises the interrupt with an exact copy.
  property p_capture;
    (state_q == hcm_pkg::ST_CHECK) && !reject
      |=> proc_irq && (proc_cmd_word == $past(cmd_q));
  endproperty
  a_capture: assert property (p_capture) // see R3
    else $error("command not captured with interrupt");

  // Completion drops the doorbell and leaves the processor's code.
  property p_complete;
    (state_q == hcm_pkg::ST_WAIT) && proc_done
      |=> !cmd_q[15] && (cmd_q[7:0] == $past(proc_result)) && !proc_irq;
  endproperty
  a_complete: assert property (p_complete) // see R4
    else $error("completion result wrong");

  // While locked every command is answered busy.
  property p_lock_busy;
    (state_q == hcm_pkg::ST_CHECK) && lock_q
      |=> (cmd_q == 16'h0009) && !proc_irq;
  endproperty
  a_lock_busy: assert property (p_lock_busy) // see R13
    else $error("locked command not busy");

  // The lock opens on configuration done and never closes again.
  property p_lock_release;
    (!lock_q || cfg_done) |=> !lock_q [*2];
  endproperty
  a_lock_release: assert property (p_lock_release) // see R14
    else $error("lock not released or re-armed");

  // A running internal command forces busy.
  property p_internal_busy;
    (state_q == hcm_pkg::ST_CHECK) && !lock_q && internal_cmd_active
      |=> cmd_q == 16'h0009;
  endproperty
  a_internal_busy: assert property (p_internal_busy) // see R16
    else $error("internal busy not reported");

  // Unknown words are refused as unsupported.
  property p_unknown;
    (state_q == hcm_pkg::ST_CHECK) && !lock_q && !internal_cmd_active &&
      !cmd_known |=> cmd_q == 16'h000f;
  endproperty
  a_unknown: assert property (p_unknown) // see R17
    else $error("unknown command not refused");

  // A status query during a running operation answers busy.
  property p_query_busy;
    (state_q == hcm_pkg::ST_CHECK) && !lock_q && !internal_cmd_active &&
      cmd_known && cmd_is_query && run_q |=> cmd_q == 16'h0009;
  endproperty
  a_query_busy: assert property (p_query_busy) // see R11
    else $error("query during run not busy");

  // Doorbell reads set for the whole time a command is open.
  property p_no_early_clear;
    (state_q != hcm_pkg::ST_IDLE) |-> cmd_q[15];
  endproperty
  a_no_early_clear: assert property (p_no_early_clear) // see R21
    else $error("doorbell cleared early");

  // An accepted asynchronous start marks the operation running.
  property p_async_run;
    (state_q == hcm_pkg::ST_WAIT) && proc_done && async_q &&
      (proc_result == 8'h00) |=> async_running && (cmd_q == 16'h0000);
  endproperty
  a_async_run: assert property (p_async_run) // see R9
    else $error("async start not tracked");

endmodule
`default_nettype wire

// ==== dv/hcm_host_model.sv ====
// Host controller model driving the decoded register port of the mailbox.
`timescale 1ns/100ps
`include "hcm_defs.svh"
`default_nettype none
module hcm_host_model (
  input wire logic clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // Every poll is bounded so that a silent device cannot hang the host.
  localparam int RETRIES = 64;
  // Set when a poll ran out of retries.
  logic timed_out = 1'b0;
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // Released address and data lines show the inverse of their last value, so stale data never matches; both enables drop to zero.
  task automatic release_bus();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // One register write: a whole 16-bit address with a whole 16-bit word.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    release_bus();
  endtask
  // One register read; the word is taken in the cycle that it is marked valid.
  // The valid pulse lasts one cycle, so the word is taken before the request drops.
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    d = reg_rd_valid ? reg_rdata : 16'hxxxx;
    release_bus();
  endtask
  // Poll the command register until the doorbell is clear; return the result word.
  task automatic wait_done(output logic [15:0] res);
    int n;
    n = RETRIES;
    res = 16'hffff;
    while (n > 0 && res[`HCM_DOORBELL_BIT] !== 1'b0) begin
      rd(`HCM_CMD_ADDR, res);
      n--;
    end
    if (res[`HCM_DOORBELL_BIT] !== 1'b0) begin
      timed_out = 1'b1;
    end
  endtask
  // Issue a command only once the previous one has completed.
  task automatic issue(input logic [15:0] w);
    logic [15:0] r;
    wait_done(r);
    wr(`HCM_CMD_ADDR, w);
  endtask
  // Start-up: repeat the system state query until it no longer answers busy.
  task automatic wait_ready(output logic [15:0] res);
    int n;
    n = RETRIES;
    res = {8'h00, `HCM_STATUS_BUSY};
    while (n > 0 && res === {8'h00, `HCM_STATUS_BUSY}) begin
      issue(16'h8101);
      wait_done(res);
      n--;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking testbench for the host command doorbell mailbox.
`timescale 1ns/100ps
`include "hcm_defs.svh"
`default_nettype none
module tb;
  logic clk;
  logic rst_b;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic cfg_done;
  logic internal_cmd_active;
  logic proc_irq, proc_cmd_async, cmd_locked, async_running;
  logic [15:0] proc_cmd_word, proc_pool_rdata;
  logic proc_done;
  logic proc_async_done;
  logic proc_pool_we;
  logic [3:0] proc_pool_idx;
  logic [15:0] proc_pool_wdata;
  // Result the processor stand-in reports, and how long it sits on a doorbell.
  logic [7:0] ack_code = 8'h00;
  int ack_wait = 1;
  int irq_age = 0;
  int errors = 0;
  int total_checks = 0;
  logic [15:0] res;
  wire logic [7:0] proc_result = ack_code;
  // The 200 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  hcm_mailbox DUT (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .cfg_done(cfg_done),
    .internal_cmd_active(internal_cmd_active), .proc_irq(proc_irq),
    .proc_cmd_word(proc_cmd_word), .proc_cmd_async(proc_cmd_async), .proc_done(proc_done),
    .proc_result(proc_result), .proc_async_done(proc_async_done),
    .proc_pool_we(proc_pool_we), .proc_pool_idx(proc_pool_idx),
    .proc_pool_wdata(proc_pool_wdata), .proc_pool_rdata(proc_pool_rdata),
    .cmd_locked(cmd_locked), .async_running(async_running));
  hcm_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));
  // Processor stand-in: answers each doorbell once it has been up ack_wait cycles.
  always @(negedge clk) begin
    proc_done <= 1'b0;
    if (proc_irq === 1'b1 && !proc_done) begin
      irq_age <= irq_age + 1;
      if (irq_age >= ack_wait) begin
        proc_done <= 1'b1;
        irq_age <= 0;
      end
    end
  end
  // Compare one value and count it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Lock from reset refuses commands busy until start-up configuration ends.
  task automatic t_startup();
    check({15'h0, cmd_locked}, 16'h0001);
    host.rd(`HCM_CMD_ADDR, res);
    check(res, 16'h0000);
    host.issue(16'h8101);
    host.wait_done(res);
    check(res, 16'h0009);
    fork
      host.wait_ready(res);
      begin
        repeat (30) @(negedge clk);
        cfg_done = 1'b1;
        @(negedge clk);
        cfg_done = 1'b0;
      end
    join
    check(res, 16'h0000);
    check({15'h0, cmd_locked}, 16'h0000);
    $display("test startup done");
  endtask
  // Synchronous command with a slow processor: capture, held doorbell, pool exchange.
  task automatic t_sync();
    ack_wait = 30;
    ack_code = `HCM_STATUS_INVALID_ARG;
    host.wr(16'hfc06, 16'h1234);
    host.issue(16'h8101);
    repeat (2) @(negedge clk);
    check({15'h0, proc_irq}, 16'h0001);
    check(proc_cmd_word, 16'h8101);
    check({15'h0, proc_cmd_async}, 16'h0000);
    host.wr(`HCM_CMD_ADDR, 16'h0000);
    host.wr(`HCM_CMD_ADDR, 16'h8200);
    host.rd(`HCM_CMD_ADDR, res);
    check(res, 16'h8101);
    check(proc_cmd_word, 16'h8101);
    proc_pool_idx = 4'h3;
    @(negedge clk);
    check(proc_pool_rdata, 16'h1234);
    proc_pool_we = 1'b1;
    proc_pool_idx = 4'h5;
    proc_pool_wdata = 16'hbeef;
    @(negedge clk);
    proc_pool_we = 1'b0;
    host.wait_done(res);
    check(res, 16'h000c);
    host.rd(16'hfc0a, res);
    check(res, 16'hbeef);
    ack_wait = 1;
    $display("test sync done");
  endtask
  // Every result code comes back in the low byte with the doorbell clear.
  task automatic t_codes();
    for (int i = 0; i <= 16; i++) begin
      ack_code = 8'(i);
      host.issue(16'h8202);
      host.wait_done(res);
      check(res, {8'h00, 8'(i)});
    end
    $display("test codes done");
  endtask
  // Asynchronous accept and refuse, then status queries while running and after.
  task automatic t_async();
    ack_code = `HCM_STATUS_NO_MEMORY;
    host.issue(16'h8100);
    host.wait_done(res);
    check(res, 16'h0007);
    check({15'h0, async_running}, 16'h0000);
    ack_code = `HCM_STATUS_OK;
    host.issue(16'h8504);
    host.wait_done(res);
    check(res, 16'h0000);
    check({15'h0, proc_cmd_async}, 16'h0001);
    check(proc_cmd_word, 16'h8504);
    check({15'h0, async_running}, 16'h0001);
    host.issue(16'h8509);
    host.wait_done(res);
    check(res, 16'h0009);
    proc_async_done = 1'b1;
    @(negedge clk);
    proc_async_done = 1'b0;
    @(negedge clk);
    check({15'h0, async_running}, 16'h0000);
    ack_code = `HCM_STATUS_IO_FAILURE;
    host.issue(16'h8509);
    host.wait_done(res);
    check(res, 16'h0003);
    $display("test async done");
  endtask
  // Internal busy, unknown command, a write without the doorbell, an unmapped read.
  task automatic t_reject();
    internal_cmd_active = 1'b1;
    host.issue(16'h8101);
    host.wait_done(res);
    check(res, 16'h0009);
    internal_cmd_active = 1'b0;
    host.issue(16'h8fff);
    host.wait_done(res);
    check(res, 16'h000f);
    host.wr(`HCM_CMD_ADDR, 16'h0101);
    host.rd(`HCM_CMD_ADDR, res);
    check(res, 16'h000f);
    host.rd(16'h1000, res);
    check(res, 16'h0000);
    $display("test reject done");
  endtask
  // Main sequence: six cycles of reset, then every scenario in turn.
  initial begin
    // Inputs start quiet while reset is held.
    rst_b = 1'b0;
    cfg_done = 1'b0;
    internal_cmd_active = 1'b0;
    proc_async_done = 1'b0;
    proc_pool_we = 1'b0;
    proc_pool_idx = 4'h0;
    proc_pool_wdata = 16'h0000;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_startup();
    t_sync();
    t_codes();
    t_async();
    t_reject();
    check({15'h0, host.timed_out}, 16'h0000);
    give_verdict();
  end
  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
